/* design/scrw_byte_decode.sv */
`default_nettype none

module scrw_byte_decode (
    input wire logic [7:0] idx_i,
    output scrw_pkg::scrw_field_t fld_o
);
    logic [7:0] ofs;

    always_comb begin
        ofs = 8'h00;
        fld_o.kind = scrw_pkg::K_NONE;
        fld_o.slave = 6'h00;
        fld_o.sub = 2'h0;
        if (idx_i < scrw_pkg::OFS_PROJ_A) begin
            fld_o.kind = scrw_pkg::K_VER;
        end else if (idx_i < scrw_pkg::OFS_PROJ_B) begin
            ofs = idx_i - scrw_pkg::OFS_PROJ_A;
            fld_o.kind = scrw_pkg::K_PROJ_A;
            fld_o.sub = ofs[1:0];
        end else if (idx_i < scrw_pkg::OFS_CFG_A) begin
            ofs = idx_i - scrw_pkg::OFS_PROJ_B;
            fld_o.kind = scrw_pkg::K_PROJ_B;
            fld_o.sub = ofs[1:0];
        end else if (idx_i < scrw_pkg::OFS_RSV) begin
            ofs = idx_i - scrw_pkg::OFS_CFG_A;
            fld_o.kind = ofs[0] ? scrw_pkg::K_EXT : scrw_pkg::K_CFG;
            fld_o.slave = {1'b0, ofs[5:1]};
        end else if (idx_i < scrw_pkg::OFS_CFG_B) begin
            fld_o.kind = scrw_pkg::K_RSV;
        end else if (idx_i < scrw_pkg::OFS_PAR_A) begin
            // B slave 1 sits where B slave 0 would be two bytes later
            ofs = idx_i - scrw_pkg::OFS_CFG_B_BASE;
            fld_o.kind = ofs[0] ? scrw_pkg::K_EXT : scrw_pkg::K_CFG;
            fld_o.slave = {1'b1, ofs[5:1]};
        end else if (idx_i < scrw_pkg::OFS_FLAG1) begin
            // Slave field holds the even (upper nibble) address
            ofs = idx_i - scrw_pkg::OFS_PAR_A;
            fld_o.kind = scrw_pkg::K_PAR;
            fld_o.slave = {ofs[4:0], 1'b0};
        end else if (idx_i == scrw_pkg::OFS_FLAG1) begin
            fld_o.kind = scrw_pkg::K_FLAG1;
        end else if (idx_i == scrw_pkg::OFS_FLAG2) begin
            fld_o.kind = scrw_pkg::K_FLAG2;
        end
    end

endmodule : scrw_byte_decode

`default_nettype wire

/* design/scrw_param_slot.sv */
`default_nettype none

module scrw_param_slot (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic wr_i,
    input wire logic [3:0] val_i,
    input wire logic managed_i,
    output logic [3:0] param_o
);
    logic [3:0] par_r;
    logic [3:0] par_nxt;

    always_comb begin
        par_nxt = par_r;
        if (wr_i && !managed_i) begin
            par_nxt = val_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            par_r <= scrw_pkg::PARAM_RST;
        end else begin
            par_r <= par_nxt;
        end
    end

    // Managed slaves always present all ones, whatever is stored
    assign param_o = managed_i ? scrw_pkg::PARAM_MANAGED : par_r;

endmodule : scrw_param_slot

`default_nettype wire

/* design/scrw_pkg.sv */
`default_nettype none

package scrw_pkg;

    // ------------------------------------------------------------
    // Record layout (byte offsets inside the configuration record)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_VER_HI = 8'h00;
    localparam logic [7:0] OFS_VER_LO = 8'h01;
    localparam logic [7:0] OFS_PROJ_A = 8'h02;
    localparam logic [7:0] OFS_PROJ_B = 8'h06;
    localparam logic [7:0] OFS_CFG_A = 8'h0a;
    localparam logic [7:0] OFS_RSV = 8'h4a;
    localparam logic [7:0] OFS_CFG_B = 8'h4c;
    localparam logic [7:0] OFS_CFG_B_BASE = 8'h4a;
    localparam logic [7:0] OFS_PAR_A = 8'h8a;
    localparam logic [7:0] OFS_PAR_B = 8'h9a;
    localparam logic [7:0] OFS_FLAG1 = 8'haa;
    localparam logic [7:0] OFS_FLAG2 = 8'hab;
    localparam logic [7:0] OFS_LAST = 8'hab;
    localparam logic [7:0] VERSION_VAL = 8'h00;
    localparam int FLAG1_CFG_MODE_BIT = 4;
    localparam int FLAG2_AUTO_EN_BIT = 3;

    // ------------------------------------------------------------
    // Parameter values and reset values
    // ------------------------------------------------------------
    localparam logic [3:0] PARAM_MANAGED = 4'hf;
    localparam logic [3:0] PARAM_RST = 4'hf;
    localparam logic CFG_MODE_RST = 1'b1;
    localparam logic AUTO_EN_RST = 1'b1;
    localparam logic [3:0] MANAGED_CODE_RST = 4'hf;
    localparam logic [15:0] SLAVE_CFG_RST = 16'hffff;

    // ------------------------------------------------------------
    // Software register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_PROJ_A = 8'h08;
    localparam logic [7:0] REG_PROJ_B = 8'h0c;
    localparam logic [7:0] REG_SEL = 8'h10;
    localparam logic [7:0] REG_SLAVE = 8'h14;
    localparam int CTRL_MANAGED_EN_BIT = 0;
    localparam int CTRL_CODE_LSB = 4;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        K_NONE, K_VER, K_PROJ_A, K_PROJ_B, K_CFG, K_EXT,
        K_RSV, K_PAR, K_FLAG1, K_FLAG2
    } scrw_kind_t;

    typedef struct packed {
        scrw_kind_t kind;
        logic [5:0] slave;
        logic [1:0] sub;
    } scrw_field_t;

    typedef struct packed {
        logic valid;
        logic sop;
        logic [7:0] data;
    } scrw_rec_byte_t;

    typedef struct packed {
        logic [3:0] io;
        logic [3:0] prof;
        logic [3:0] ext1;
        logic [3:0] ext2;
    } scrw_slave_cfg_t;

    typedef struct packed {
        logic valid;
        logic [5:0] addr;
        logic [3:0] data;
    } scrw_param_tx_t;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_SCAN = 2'b01,
        S_SEND = 2'b11
    } scrw_send_state_t;

endpackage : scrw_pkg

`default_nettype wire

/* design/scrw_record_writer.sv */
`default_nettype none

module scrw_record_writer (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire scrw_pkg::scrw_rec_byte_t rec_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic master_start_i,
    input wire logic param_ready_i,
    output scrw_pkg::scrw_param_tx_t param_o,
    output logic config_mode_o,
    output logic auto_address_enable_o,
    output logic nv_commit_o,
    output logic rec_error_o
);
    // ------------------------------------------------------------
    // Record intake
    // ------------------------------------------------------------
    logic act_r, act_nxt;
    logic err_r, err_nxt;
    logic [7:0] idx_r, idx_nxt;
    logic commit_r, commit_nxt;
    logic acc;
    logic wr_ok;
    logic [7:0] cur_idx;
    scrw_pkg::scrw_field_t fld;

    assign acc = rec_i.valid && (rec_i.sop || act_r);
    assign cur_idx = rec_i.sop ? scrw_pkg::OFS_VER_HI : idx_r;
    // Version faults are known before byte 2, so later bytes see err_r
    assign wr_ok = acc && !rec_i.sop && !err_r;

    scrw_byte_decode u_dec (
        .idx_i(cur_idx),
        .fld_o(fld)
    );

    always_comb begin
        act_nxt = act_r;
        err_nxt = err_r;
        idx_nxt = idx_r;
        commit_nxt = 1'b0;
        if (acc) begin
            idx_nxt = cur_idx + 8'h01;
            act_nxt = (cur_idx != scrw_pkg::OFS_LAST);
            if (rec_i.sop) begin
                err_nxt = (rec_i.data != scrw_pkg::VERSION_VAL);
            end else if (cur_idx == scrw_pkg::OFS_VER_LO &&
                         rec_i.data != scrw_pkg::VERSION_VAL) begin
                err_nxt = 1'b1;
            end
            if (cur_idx == scrw_pkg::OFS_LAST && !err_r) begin
                commit_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            act_r <= 1'b0;
            err_r <= 1'b0;
            idx_r <= 8'h00;
            commit_r <= 1'b0;
        end else begin
            act_r <= act_nxt;
            err_r <= err_nxt;
            idx_r <= idx_nxt;
            commit_r <= commit_nxt;
        end
    end

    // ------------------------------------------------------------
    // Configuration store
    // ------------------------------------------------------------
    logic [31:0] proj_a_r, proj_a_nxt;
    logic [31:0] proj_b_r, proj_b_nxt;
    scrw_pkg::scrw_slave_cfg_t [63:0] cfg_r, cfg_nxt;
    logic cfg_mode_r, cfg_mode_nxt;
    logic auto_en_r, auto_en_nxt;

    always_comb begin
        proj_a_nxt = proj_a_r;
        proj_b_nxt = proj_b_r;
        cfg_nxt = cfg_r;
        cfg_mode_nxt = cfg_mode_r;
        auto_en_nxt = auto_en_r;
        if (wr_ok) begin
            case (fld.kind)
                scrw_pkg::K_PROJ_A: begin
                    proj_a_nxt[fld.sub*8 +: 8] = rec_i.data;
                end
                scrw_pkg::K_PROJ_B: begin
                    proj_b_nxt[fld.sub*8 +: 8] = rec_i.data;
                end
                scrw_pkg::K_CFG: begin
                    cfg_nxt[fld.slave].io = rec_i.data[7:4];
                    cfg_nxt[fld.slave].prof = rec_i.data[3:0];
                end
                scrw_pkg::K_EXT: begin
                    cfg_nxt[fld.slave].ext1 = rec_i.data[7:4];
                    cfg_nxt[fld.slave].ext2 = rec_i.data[3:0];
                end
                scrw_pkg::K_FLAG1: begin
                    // Only the mode bit is taken; status bits stay as is
                    cfg_mode_nxt =
                        rec_i.data[scrw_pkg::FLAG1_CFG_MODE_BIT];
                end
                scrw_pkg::K_FLAG2: begin
                    auto_en_nxt =
                        rec_i.data[scrw_pkg::FLAG2_AUTO_EN_BIT];
                end
                default: begin
                    // Reserved bytes and version bytes store nothing
                    cfg_mode_nxt = cfg_mode_r;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            proj_a_r <= 32'h0000_0000;
            proj_b_r <= 32'h0000_0000;
            cfg_r <= {64{scrw_pkg::SLAVE_CFG_RST}};
            cfg_mode_r <= scrw_pkg::CFG_MODE_RST;
            auto_en_r <= scrw_pkg::AUTO_EN_RST;
        end else begin
            proj_a_r <= proj_a_nxt;
            proj_b_r <= proj_b_nxt;
            cfg_r <= cfg_nxt;
            cfg_mode_r <= cfg_mode_nxt;
            auto_en_r <= auto_en_nxt;
        end
    end

    // ------------------------------------------------------------
    // Parameter slots
    // ------------------------------------------------------------
    logic managed_en_r, managed_en_nxt;
    logic [3:0] managed_code_r, managed_code_nxt;
    logic [63:0][3:0] par_w;
    logic par_wr;

    assign par_wr = wr_ok && (fld.kind == scrw_pkg::K_PAR);

    for (genvar i = 0; i < 64; i++) begin : g_slot
        localparam logic [5:0] SLOT = 6'(i);
        logic we;
        logic mg;
        // Upper nibble of the first byte of each half is reserved
        assign we = par_wr && (fld.slave[5:1] == SLOT[5:1]) &&
                    (SLOT[0] || (SLOT[4:0] != 5'h00));
        assign mg = managed_en_r && (cfg_r[i].prof == managed_code_r);
        scrw_param_slot u_slot (
            .clk_i(clk_i),
            .arst_n_i(arst_n_i),
            .wr_i(we),
            .val_i(SLOT[0] ? rec_i.data[3:0] : rec_i.data[7:4]),
            .managed_i(mg),
            .param_o(par_w[i])
        );
    end

    // ------------------------------------------------------------
    // Parameter download at master start
    // ------------------------------------------------------------
    scrw_pkg::scrw_send_state_t st_r, st_nxt;
    logic [5:0] sidx_r, sidx_nxt;
    logic [5:0] tx_addr_r, tx_addr_nxt;
    logic [3:0] tx_data_r, tx_data_nxt;
    logic [63:0] proj_all;

    assign proj_all = {proj_b_r, proj_a_r};

    always_comb begin
        st_nxt = st_r;
        sidx_nxt = sidx_r;
        tx_addr_nxt = tx_addr_r;
        tx_data_nxt = tx_data_r;
        case (st_r)
            scrw_pkg::S_IDLE: begin
                if (master_start_i) begin
                    sidx_nxt = 6'h01; // Address 0 takes no parameter
                    st_nxt = scrw_pkg::S_SCAN;
                end
            end
            scrw_pkg::S_SCAN: begin
                if (proj_all[sidx_r]) begin
                    tx_addr_nxt = sidx_r;
                    tx_data_nxt = par_w[sidx_r];
                    st_nxt = scrw_pkg::S_SEND;
                end else if (sidx_r == 6'h3f) begin
                    st_nxt = scrw_pkg::S_IDLE;
                end else begin
                    sidx_nxt = sidx_r + 6'h01;
                end
            end
            scrw_pkg::S_SEND: begin
                if (param_ready_i) begin
                    sidx_nxt = sidx_r + 6'h01;
                    st_nxt = (sidx_r == 6'h3f) ? scrw_pkg::S_IDLE
                                               : scrw_pkg::S_SCAN;
                end
            end
            default: begin
                st_nxt = scrw_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r <= scrw_pkg::S_IDLE;
            sidx_r <= 6'h00;
            tx_addr_r <= 6'h00;
            tx_data_r <= 4'h0;
        end else begin
            st_r <= st_nxt;
            sidx_r <= sidx_nxt;
            tx_addr_r <= tx_addr_nxt;
            tx_data_r <= tx_data_nxt;
        end
    end

    assign param_o.valid = (st_r == scrw_pkg::S_SEND);
    assign param_o.addr = tx_addr_r;
    assign param_o.data = tx_data_r;

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    logic [5:0] sel_r, sel_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    always_comb begin
        managed_en_nxt = managed_en_r;
        managed_code_nxt = managed_code_r;
        sel_nxt = sel_r;
        rdata_nxt = 32'h0000_0000;
        if (reg_wr_i) begin
            case (reg_addr_i)
                scrw_pkg::REG_CTRL: begin
                    managed_en_nxt =
                        reg_wdata_i[scrw_pkg::CTRL_MANAGED_EN_BIT];
                    managed_code_nxt =
                        reg_wdata_i[scrw_pkg::CTRL_CODE_LSB +: 4];
                end
                scrw_pkg::REG_SEL: begin
                    sel_nxt = reg_wdata_i[5:0];
                end
                default: begin
                    sel_nxt = sel_r;
                end
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                scrw_pkg::REG_CTRL: begin
                    rdata_nxt = {24'h00_0000, managed_code_r, 3'h0,
                                 managed_en_r};
                end
                scrw_pkg::REG_STATUS: begin
                    rdata_nxt = {27'h000_0000, param_o.valid, act_r,
                                 err_r, auto_en_r, cfg_mode_r};
                end
                scrw_pkg::REG_PROJ_A: rdata_nxt = proj_a_r;
                scrw_pkg::REG_PROJ_B: rdata_nxt = proj_b_r;
                scrw_pkg::REG_SEL: rdata_nxt = {26'h000_0000, sel_r};
                scrw_pkg::REG_SLAVE: begin
                    rdata_nxt = {12'h000, par_w[sel_r], cfg_r[sel_r]};
                end
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            managed_en_r <= 1'b0;
            managed_code_r <= scrw_pkg::MANAGED_CODE_RST;
            sel_r <= 6'h00;
            rdata_r <= 32'h0000_0000;
        end else begin
            managed_en_r <= managed_en_nxt;
            managed_code_r <= managed_code_nxt;
            sel_r <= sel_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign config_mode_o = cfg_mode_r;
    assign auto_address_enable_o = auto_en_r;
    assign nv_commit_o = commit_r;
    assign rec_error_o = err_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    property p_ver_reject;
        rec_i.valid && rec_i.sop && rec_i.data != 8'h00 |=> err_r;
    endproperty
    a_ver_reject: assert property (p_ver_reject)
        else $error("nonzero version not flagged");

    property p_proj_a;
        wr_ok && cur_idx == 8'h03 |=> proj_a_r[15:8] == $past(rec_i.data);
    endproperty
    a_proj_a: assert property (p_proj_a)
        else $error("projected A byte not stored");

    property p_proj_b;
        wr_ok && cur_idx == 8'h09 |=> proj_b_r[31:24] == $past(rec_i.data);
    endproperty
    a_proj_b: assert property (p_proj_b)
        else $error("projected B byte not stored");

    property p_cfg_a;
        wr_ok && cur_idx == 8'h0c |=>
            {cfg_r[1].io, cfg_r[1].prof} == $past(rec_i.data);
    endproperty
    a_cfg_a: assert property (p_cfg_a)
        else $error("slave 1 configuration not stored");

    property p_ext_b;
        wr_ok && cur_idx == 8'h89 |=>
            {cfg_r[63].ext1, cfg_r[63].ext2} == $past(rec_i.data);
    endproperty
    a_ext_b: assert property (p_ext_b)
        else $error("slave 31B extended codes not stored");

    property p_rsv;
        wr_ok && cur_idx == 8'h4a |=> $stable(cfg_r) && !err_r;
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved byte altered the store");

    property p_flag1;
        wr_ok && cur_idx == 8'haa |=>
            cfg_mode_r == $past(rec_i.data[4]) && $stable(auto_en_r);
    endproperty
    a_flag1: assert property (p_flag1)
        else $error("flag byte one misapplied");

    property p_flag2;
        wr_ok && cur_idx == 8'hab |=>
            auto_en_r == $past(rec_i.data[3]) && $stable(cfg_mode_r);
    endproperty
    a_flag2: assert property (p_flag2)
        else $error("flag byte two misapplied");

    property p_managed;
        managed_en_r && cfg_r[5].prof == managed_code_r |->
            par_w[5] == 4'hf;
    endproperty
    a_managed: assert property (p_managed)
        else $error("managed slave parameter not all ones");

    property p_commit;
        acc && cur_idx == 8'hab && !err_r |=> nv_commit_o ##1 !nv_commit_o;
    endproperty
    a_commit: assert property (p_commit)
        else $error("commit pulse missing after last byte");

    property p_send;
        st_r == scrw_pkg::S_SEND |-> proj_all[tx_addr_r];
    endproperty
    a_send: assert property (p_send)
        else $error("parameter sent to unprojected slave");

endmodule : scrw_record_writer

`default_nettype wire

/* verification/scrw_ctrl_model.sv */
`default_nettype none

module scrw_ctrl_model (
    input wire logic clk_i,
    output var scrw_pkg::scrw_rec_byte_t rec_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial rec_o = '0;

    // ----
    // Record sender with random gaps
    // ----
    // Idle data is the inverse of the last byte so no stale copy can match
    task automatic send(input logic [7:0] b [172]);
        for (int i = 0; i < 172; i++) begin
            @(posedge clk_i);
            rec_o <= '{1'b1, i == 0, b[i]};
            if ($urandom_range(3) == 0) begin
                @(posedge clk_i);
                rec_o <= '{1'b0, 1'b0, ~b[i]};
            end
        end
        @(posedge clk_i);
        rec_o <= '{1'b0, 1'b0, ~b[171]};
    endtask : send
endmodule : scrw_ctrl_model

`default_nettype wire

/* verification/tb.sv */
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    scrw_pkg::scrw_rec_byte_t rec;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic master_start_i = 1'b0;
    logic param_ready_i = 1'b0;
    scrw_pkg::scrw_param_tx_t param_o;
    logic config_mode_o, auto_address_enable_o, nv_commit_o, rec_error_o;
    logic [7:0] rb [172];
    logic [7:0] keep [172];
    logic [31:0] rd;
    logic [3:0] code = 4'hf;
    logic man = 1'b0;
    int err_count = 0;
    int check_count = 0;
    int commits = 0;

    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) if (nv_commit_o === 1'b1) commits <= commits + 1;

    scrw_ctrl_model i_scrw_ctrl_model (.clk_i(clk_i), .rec_o(rec));
    scrw_record_writer i_scrw_record_writer (.clk_i(clk_i),
        .arst_n_i(arst_n_i), .rec_i(rec), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .master_start_i(master_start_i),
        .param_ready_i(param_ready_i), .param_o(param_o),
        .config_mode_o(config_mode_o),
        .auto_address_enable_o(auto_address_enable_o),
        .nv_commit_o(nv_commit_o), .rec_error_o(rec_error_o));

    // ----
    // Helpers
    // ----
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 rd = reg_rdata_o;
    endtask : rdr

    function automatic bit prj(input int s);
        return rb[(s < 32 ? 2 : 6) + (s % 32) / 8][s % 8];
    endfunction : prj

    // Slot 0 of each list has no parameter byte, B0 no config bytes
    function automatic logic [19:0] exp_slave(input int s);
        logic [15:0] c;
        logic [3:0] p;
        int n;
        int pb;
        n = s % 32;
        c = {rb[(s < 32 ? 10 : 74) + 2 * n], rb[(s < 32 ? 11 : 75) + 2 * n]};
        if (s == 32) c = 16'hffff;
        pb = (s < 32 ? 138 : 154) + n / 2;
        p = (n % 2 == 0) ? rb[pb][7:4] : rb[pb][3:0];
        if (n == 0 || (man && c[11:8] == code)) p = 4'hf;
        return {p, c};
    endfunction : exp_slave

    task automatic build;
        foreach (rb[i]) rb[i] = 8'($urandom);
        rb[0] = 8'h00;
        rb[1] = 8'h00;
    endtask : build

    task automatic put(input int nc, input logic e);
        repeat (3) @(posedge clk_i);
        chk("commits", nc, commits);
        chk("rec_error", e, rec_error_o);
        chk("cfg_mode", rb[170][4], config_mode_o);
        chk("auto_en", rb[171][3], auto_address_enable_o);
        rdr(scrw_pkg::REG_STATUS);
        chk("status", {29'h0, e, rb[171][3], rb[170][4]}, rd);
        rdr(scrw_pkg::REG_PROJ_A);
        chk("proj_a", {rb[5], rb[4], rb[3], rb[2]}, rd);
        rdr(scrw_pkg::REG_PROJ_B);
        chk("proj_b", {rb[9], rb[8], rb[7], rb[6]}, rd);
        for (int s = 0; s < 64; s++) begin
            wr(scrw_pkg::REG_SEL, 32'(s));
            rdr(scrw_pkg::REG_SLAVE);
            chk("slave", 32'(exp_slave(s)), rd);
        end
    endtask : put

    task automatic download;
        logic [5:0] q [$];
        int t;
        for (int s = 1; s < 64; s++) if (prj(s)) q.push_back(6'(s));
        @(posedge clk_i);
        master_start_i <= 1'b1;
        @(posedge clk_i);
        master_start_i <= 1'b0;
        t = 0;
        while (t < 1000 && (q.size() > 0 || param_o.valid !== 1'b0)) begin
            t++;
            @(negedge clk_i);
            if (param_o.valid === 1'b1 && param_ready_i) begin
                if (q.size() == 0) chk("extra", 0, 1);
                else begin
                    chk("p_addr", 32'(q[0]), 32'(param_o.addr));
                    chk("p_data", 32'(exp_slave(q[0]) >> 16), 32'(param_o.data));
                    void'(q.pop_front());
                end
            end
            @(posedge clk_i);
            param_ready_i <= 1'($urandom);
        end
        chk("left", 0, q.size());
        // Let the edge pass so ready is not driven twice in one step
        @(posedge clk_i);
        param_ready_i <= 1'b0;
    endtask : download

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    // ----
    // Main sequence
    // ----
    initial begin
        void'($urandom(32'h1c20));
        fork
            begin
                #500us;
                err_count++;
                tally_and_finish();
            end
        join_none
        repeat (10) @(posedge clk_i);
        arst_n_i <= 1'b1;
        rdr(scrw_pkg::REG_STATUS);
        chk("status_rst", 32'h3, rd);
        rdr(8'h18);
        chk("unmapped", 0, rd);
        wr(scrw_pkg::REG_CTRL, 32'h0);
        build;
        // Every ignored flag set, both mode flags cleared
        rb[170] = 8'hef;
        rb[171] = 8'hf7;
        i_scrw_ctrl_model.send(rb);
        put(1, 1'b0);
        download;
        build;
        code = rb[20][3:0];
        man = 1'b1;
        wr(scrw_pkg::REG_CTRL, {24'h0, code, 4'h1});
        i_scrw_ctrl_model.send(rb);
        put(2, 1'b0);
        keep = rb;
        build;
        rb[1] = 8'h5a;
        i_scrw_ctrl_model.send(rb);
        rb = keep;
        put(2, 1'b1);
        build;
        i_scrw_ctrl_model.send(rb);
        put(3, 1'b0);
        download;
        tally_and_finish();
    end
endmodule : tb

`default_nettype wire
